//--- src/analog_output_ctrl.sv
`timescale 1ns/1ps
`include "ao_ctrl_defs.svh"

module analog_output_ctrl (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        prm_wr_in,
	input  wire logic        prm_rec_in,
	input  wire logic [3:0]  prm_addr_in,
	input  wire logic [7:0]  prm_data_in,
	input  wire logic        val_wr_in,
	input  wire logic [1:0]  val_ch_in,
	input  wire logic [15:0] val_data_in,
	input  wire logic        run_in,
	input  wire logic [3:0]  wire_break_in,
	input  wire logic [3:0]  short_gnd_in,
	input  wire logic [3:0]  manual_sw_in,
	input  wire logic        ext_supply_ok_in,
	input  wire logic        diag_rd_in,
	input  wire logic [1:0]  diag_addr_in,
	output logic      [7:0]  diag_data_out,
	output logic      [3:0]  ch_en_out,
	output logic      [3:0]  ch_curr_out,
	output logic      [15:0] ch_range_out,
	output logic      [63:0] drive_word_out,
	output logic      [3:0]  ch_over_out,
	output logic      [3:0]  ch_under_out,
	output logic             diag_irq_out,
	output logic      [31:0] diag_record_out
);

	// ****************************************************************
	// Parameter storage
	// ****************************************************************
	logic [7:0]  mode_q [4];
	logic [15:0] val_q  [4];
	logic [3:0]  grp_en_q;
	logic        irq_rel_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 4; i++) begin
				mode_q[i] <= `MODE_RST;
			end
		end else if (prm_wr_in && prm_rec_in == `REC_PRM_SEL &&
			prm_addr_in >= `PRM_MODE_BASE && prm_addr_in <= `PRM_MODE_LAST) begin
			mode_q[2'(prm_addr_in - `PRM_MODE_BASE)] <= prm_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_rel_q <= 1'b0;
			grp_en_q  <= 4'h0;
		end else if (prm_wr_in) begin
			if (prm_rec_in == `REC_PRM_SEL && prm_addr_in == `PRM_IRQ_CFG_ADDR) begin
				irq_rel_q <= prm_data_in[`PRM_IRQ_REL_BIT];
			end
			if (prm_rec_in == `REC_DIAG_SEL && prm_addr_in == `GRP_EN_ADDR) begin
				grp_en_q <= prm_data_in[3:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 4; i++) begin
				val_q[i] <= `ZERO_WORD;
			end
		end else if (val_wr_in) begin
			val_q[val_ch_in] <= val_data_in;
		end
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic [3:0]  brk_s;
	logic [3:0]  sht_s;
	logic [3:0]  man_s;
	logic        sup_ok_s;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_q <= 13'h1000;
			sync2_q <= 13'h1000;
		end else begin
			sync1_q <= {ext_supply_ok_in, manual_sw_in, short_gnd_in, wire_break_in};
			sync2_q <= sync1_q;
		end
	end

	assign brk_s    = sync2_q[3:0];
	assign sht_s    = sync2_q[7:4];
	assign man_s    = sync2_q[11:8];
	assign sup_ok_s = sync2_q[12];

	// ****************************************************************
	// Per-channel decode and output mapping
	// ****************************************************************
	logic [3:0] perr;
	logic [3:0] ch_err;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			ao_ctrl_pkg::out_type_t otype;
			ao_ctrl_pkg::region_t   reg_d;
			logic [3:0]  rng;
			logic [3:0]  typ;
			logic        valid;
			logic        bip;
			logic        live;
			logic [15:0] lo_end;
			logic [15:0] word_d;

			assign rng = mode_q[g][`MODE_RANGE];
			assign typ = mode_q[g][`MODE_TYPE];

			always_comb begin
				valid = 1'b0;
				bip   = 1'b0;
				live  = 1'b0;
				otype = ao_ctrl_pkg::OT_OFF;
				if (typ == `TYPE_VOLT) begin
					valid = rng == `RNG_V_0_10 || rng == `RNG_V_1_5 || rng == `RNG_V_BIP;
					bip   = rng == `RNG_V_BIP;
					live  = rng == `RNG_V_1_5;
					otype = valid ? ao_ctrl_pkg::OT_VOLT : ao_ctrl_pkg::OT_OFF;
				end else if (typ == `TYPE_CURR) begin
					valid = rng == `RNG_I_0_20 || rng == `RNG_I_4_20 || rng == `RNG_I_BIP;
					bip   = rng == `RNG_I_BIP;
					live  = rng == `RNG_I_4_20;
					otype = valid ? ao_ctrl_pkg::OT_CURR : ao_ctrl_pkg::OT_OFF;
				end
			end

			// Unsupported mode is refused, channel stays off
			assign perr[g] = mode_q[g] != `MODE_OFF && !valid;

			always_comb begin
				lo_end = `ZERO_WORD;
				if (bip) begin
					lo_end = `UNDER_END_BIP;
				end else if (live) begin
					lo_end = `UNDER_END_LIVE;
				end
			end

			always_comb begin
				word_d = val_q[g];
				reg_d  = ao_ctrl_pkg::RG_NOM;
				if ($signed(val_q[g]) > $signed(`OVER_END)) begin
					word_d = `OVER_END;
					reg_d  = ao_ctrl_pkg::RG_OVER;
				end else if ($signed(val_q[g]) > $signed(`NOM_MAX)) begin
					reg_d  = ao_ctrl_pkg::RG_OVER;
				end else if ($signed(val_q[g]) < $signed(lo_end)) begin
					word_d = lo_end;
					reg_d  = ao_ctrl_pkg::RG_UNDER;
				end else if ($signed(val_q[g]) < $signed(`ZERO_WORD) &&
					!(bip && $signed(val_q[g]) >= $signed(`NOM_MIN_BIP))) begin
					reg_d  = ao_ctrl_pkg::RG_UNDER;
				end
				if (otype == ao_ctrl_pkg::OT_OFF) begin
					word_d = `ZERO_WORD;
					reg_d  = ao_ctrl_pkg::RG_NOM;
				end
			end

			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					ch_en_out[g]               <= 1'b0;
					ch_curr_out[g]             <= 1'b0;
					ch_range_out[4*g +: 4]     <= 4'h0;
					drive_word_out[16*g +: 16] <= `ZERO_WORD;
					ch_over_out[g]             <= 1'b0;
					ch_under_out[g]            <= 1'b0;
				end else begin
					ch_en_out[g]               <= otype != ao_ctrl_pkg::OT_OFF;
					ch_curr_out[g]             <= otype == ao_ctrl_pkg::OT_CURR;
					ch_range_out[4*g +: 4]     <= rng;
					drive_word_out[16*g +: 16] <= word_d;
					ch_over_out[g]             <= reg_d == ao_ctrl_pkg::RG_OVER;
					ch_under_out[g]            <= reg_d == ao_ctrl_pkg::RG_UNDER;
				end
			end

			// Wire break only meaningful on a driven current output
			assign ch_err[g] = grp_en_q[g] && (perr[g] || sht_s[g] || man_s[g] ||
				(brk_s[g] && otype == ao_ctrl_pkg::OT_CURR));
		end
	endgenerate

	// ****************************************************************
	// Diagnostic record and interrupt
	// ****************************************************************
	logic [7:0] diag0_d;
	logic [7:0] diag0_q;
	logic [7:0] diag2_q;
	logic       sup_miss;

	assign sup_miss = !sup_ok_s && (|grp_en_q);

	always_comb begin
		diag0_d                  = `BYTE_ZERO;
		diag0_d[`DIAG_B0_SUPPLY] = sup_miss;
		diag0_d[`DIAG_B0_EXT]    = sup_miss;
		diag0_d[`DIAG_B0_CHAN]   = |ch_err;
		diag0_d[`DIAG_B0_PARAM]  = |(perr & grp_en_q);
		diag0_d[`DIAG_B0_MODULE] = sup_miss || (|ch_err);
	end

	// Recomputed every cycle so a corrected error clears itself
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			diag0_q <= `BYTE_ZERO;
			diag2_q <= `BYTE_ZERO;
		end else begin
			diag0_q                  <= diag0_d;
			diag2_q                  <= `BYTE_ZERO;
			diag2_q[`DIAG_B2_OP_BIT] <= run_in;
		end
	end

	logic event_d;
	assign event_d = diag0_d != diag0_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			diag_irq_out    <= 1'b0;
			diag_record_out <= 32'h0000_0000;
		end else begin
			diag_irq_out <= irq_rel_q && event_d;
			if (irq_rel_q && event_d) begin
				diag_record_out <= {`BYTE_ZERO, diag2_q, `DIAG_B1_VAL, diag0_d};
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			diag_data_out <= `BYTE_ZERO;
		end else if (diag_rd_in) begin
			case (diag_addr_in)
				`DIAG_B0_ADDR: diag_data_out <= diag0_q;
				`DIAG_B1_ADDR: diag_data_out <= `DIAG_B1_VAL;
				`DIAG_B2_ADDR: diag_data_out <= diag2_q;
				default:       diag_data_out <= `BYTE_ZERO;
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	property p_mode_off;
		mode_q[2] == `MODE_OFF |=> !ch_en_out[2] && drive_word_out[47:32] == `ZERO_WORD;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("off channel driven");
	property p_volt;
		mode_q[0] == 8'h18 |=> ch_en_out[0] && !ch_curr_out[0] && ch_range_out[3:0] == 4'h8;
	endproperty
	a_volt: assert property (p_volt) else $error("voltage mode not decoded");
	property p_curr;
		mode_q[0] == 8'h23 |=> ch_en_out[0] && ch_curr_out[0] && ch_range_out[3:0] == 4'h3;
	endproperty
	a_curr: assert property (p_curr) else $error("current mode not decoded");
	property p_clamp_hi;
		ch_en_out[0] && $signed(val_q[0]) > 16'sh7eff && $stable(mode_q[0])
			|=> drive_word_out[15:0] == 16'h7eff && ch_over_out[0];
	endproperty
	a_clamp_hi: assert property (p_clamp_hi) else $error("overdrive not clamped");
	property p_bip_lo;
		mode_q[2] == 8'h19 && $signed(val_q[2]) < 16'sh8100
			|=> drive_word_out[47:32] == 16'h8100 && ch_under_out[2];
	endproperty
	a_bip_lo: assert property (p_bip_lo) else $error("bipolar underdrive wrong");
	property p_live_lo;
		mode_q[0] == 8'h23 && $signed(val_q[0]) < 16'she500
			|=> drive_word_out[15:0] == 16'he500;
	endproperty
	a_live_lo: assert property (p_live_lo) else $error("live zero floor wrong");
	property p_gate;
		grp_en_q == 4'h0 [*2] |-> diag0_q[`DIAG_B0_CHAN] == 1'b0 && diag0_q[`DIAG_B0_PARAM] == 1'b0;
	endproperty
	a_gate: assert property (p_gate) else $error("error recorded while gated");
	property p_irq_cause;
		diag_irq_out |-> $past(irq_rel_q) && diag0_q != $past(diag0_q);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");
	property p_irq_clear;
		irq_rel_q && diag0_q != `BYTE_ZERO && diag0_d == `BYTE_ZERO |=> diag_irq_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("no interrupt on clear");
	property p_perr;
		grp_en_q[3] && mode_q[3] == 8'h55 [*3] |-> diag0_q[`DIAG_B0_PARAM];
	endproperty
	a_perr: assert property (p_perr) else $error("parameter error missing");
	property p_byte1;
		diag_rd_in && diag_addr_in == `DIAG_B1_ADDR |=> diag_data_out == 8'h15;
	endproperty
	a_byte1: assert property (p_byte1) else $error("class byte wrong");
	property p_rsvd;
		diag0_q[1] == 1'b0 && diag0_q[6:5] == 2'b00 && diag_record_out[31:24] == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	c_irq:    cover property (irq_rel_q ##1 diag_irq_out);
	c_over:   cover property (ch_over_out[0] && ch_en_out[0]);
	c_under:  cover property (ch_under_out[1] && ch_en_out[1]);
	c_supply: cover property (diag0_q[`DIAG_B0_SUPPLY] ##[1:20] !diag0_q[`DIAG_B0_SUPPLY]);

endmodule

//--- src/ao_ctrl_defs.svh
`ifndef AO_CTRL_DEFS_SVH
`define AO_CTRL_DEFS_SVH

// ****************************************************************
// Parameter record layout
// ****************************************************************
`define REC_DIAG_SEL      1'b0
`define REC_PRM_SEL       1'b1
`define PRM_IRQ_CFG_ADDR  4'h0
`define PRM_MODE_BASE     4'h2
`define PRM_MODE_LAST     4'h5
`define PRM_IRQ_REL_BIT   6
`define GRP_EN_ADDR       4'h0
`define MODE_RST          8'h19
`define MODE_OFF          8'h00

// ****************************************************************
// Mode byte fields and codes
// ****************************************************************
`define MODE_RANGE        3:0
`define MODE_TYPE         7:4
`define TYPE_VOLT         4'h1
`define TYPE_CURR         4'h2
`define RNG_V_0_10        4'h8
`define RNG_V_1_5         4'h7
`define RNG_V_BIP         4'h9
`define RNG_I_0_20        4'h2
`define RNG_I_4_20        4'h3
`define RNG_I_BIP         4'h4

// ****************************************************************
// Output word limits (two's complement)
// ****************************************************************
`define NOM_MAX           16'h6c00
`define OVER_END          16'h7eff
`define NOM_MIN_BIP       16'h9400
`define UNDER_END_BIP     16'h8100
`define UNDER_END_LIVE    16'he500
`define ZERO_WORD         16'h0000

// ****************************************************************
// Diagnostic record
// ****************************************************************
`define DIAG_B0_ADDR      2'h0
`define DIAG_B1_ADDR      2'h1
`define DIAG_B2_ADDR      2'h2
`define DIAG_B0_MODULE    0
`define DIAG_B0_EXT       2
`define DIAG_B0_CHAN      3
`define DIAG_B0_SUPPLY    4
`define DIAG_B0_PARAM     7
`define DIAG_B1_VAL       8'h15
`define DIAG_B2_OP_BIT    2
`define BYTE_ZERO         8'h00

`endif

//--- src/ao_ctrl_pkg.sv
package ao_ctrl_pkg;

	typedef enum logic [1:0] {
		OT_OFF,
		OT_VOLT,
		OT_CURR
	} out_type_t;

	typedef enum logic [1:0] {
		RG_NOM,
		RG_OVER,
		RG_UNDER
	} region_t;

endpackage

//--- tb/ao_cpu_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Controller side: parameter writes, output words, diag reads
// ****************************************************************
module ao_cpu_model (
	input  wire logic        clk_in,
	input  wire logic [7:0]  diag_data_in,
	output logic             prm_wr_out,
	output logic             prm_rec_out,
	output logic      [3:0]  prm_addr_out,
	output logic      [7:0]  prm_data_out,
	output logic             val_wr_out,
	output logic      [1:0]  val_ch_out,
	output logic      [15:0] val_data_out,
	output logic             diag_rd_out,
	output logic      [1:0]  diag_addr_out
);
	initial begin
		prm_wr_out = 1'b0;
		prm_rec_out = 1'b0;
		prm_addr_out = 4'hf;
		prm_data_out = 8'h00;
		val_wr_out = 1'b0;
		val_ch_out = 2'h0;
		val_data_out = 16'h0000;
		diag_rd_out = 1'b0;
		diag_addr_out = 2'h0;
	end

	// Released data buses and the read address show the inverse so stale data cannot pass
	task automatic prm(input logic rec, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		prm_wr_out = 1'b1;
		prm_rec_out = rec;
		prm_addr_out = a;
		prm_data_out = d;
		@(posedge clk_in);
		#1;
		prm_wr_out = 1'b0;
		prm_data_out = ~d;
	endtask

	task automatic word(input logic [1:0] ch, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		val_wr_out = 1'b1;
		val_ch_out = ch;
		val_data_out = d;
		@(posedge clk_in);
		#1;
		val_wr_out = 1'b0;
		val_data_out = ~d;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		diag_rd_out = 1'b1;
		diag_addr_out = a;
		@(posedge clk_in);
		#1;
		diag_rd_out = 1'b0;
		diag_addr_out = ~a;
		d = diag_data_in;
	endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk_in;
	logic        nrst_in;
	logic        prm_wr, prm_rec, val_wr, diag_rd, run_in, ext_ok, irq;
	logic [3:0]  prm_addr, wire_break, short_gnd, manual_sw, en, curr, over, under;
	logic [7:0]  prm_data, diag_data;
	logic [1:0]  val_ch, diag_addr;
	logic [15:0] val_data, rng;
	logic [63:0] drv;
	logic [31:0] rec;
	int          miscompares;
	int          num_checks;

	analog_output_ctrl uut (.clk_in(clk_in), .nrst_in(nrst_in), .prm_wr_in(prm_wr),
		.prm_rec_in(prm_rec), .prm_addr_in(prm_addr), .prm_data_in(prm_data),
		.val_wr_in(val_wr), .val_ch_in(val_ch), .val_data_in(val_data), .run_in(run_in),
		.wire_break_in(wire_break), .short_gnd_in(short_gnd), .manual_sw_in(manual_sw),
		.ext_supply_ok_in(ext_ok), .diag_rd_in(diag_rd), .diag_addr_in(diag_addr),
		.diag_data_out(diag_data), .ch_en_out(en), .ch_curr_out(curr), .ch_range_out(rng),
		.drive_word_out(drv), .ch_over_out(over), .ch_under_out(under),
		.diag_irq_out(irq), .diag_record_out(rec));

	ao_cpu_model cpu (.clk_in(clk_in), .diag_data_in(diag_data), .prm_wr_out(prm_wr),
		.prm_rec_out(prm_rec), .prm_addr_out(prm_addr), .prm_data_out(prm_data),
		.val_wr_out(val_wr), .val_ch_out(val_ch), .val_data_out(val_data),
		.diag_rd_out(diag_rd), .diag_addr_out(diag_addr));

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.rd(a, d);
		chk(d, exp, "diag byte");
	endtask

	// Pulse lasts one cycle, so look after every edge
	task automatic wait_irq(input logic exp, input logic [7:0] b0, input logic [7:0] mk);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 12 && !seen; n++) begin
			tick(1);
			seen = (irq === 1'b1);
		end
		chk(seen, exp, "irq");
		if (seen) chk({rec[31:8], rec[7:0] & mk}, {8'h00, 5'h00, run_in, 2'b00, 8'h15, b0 & mk}, "record");
		if (exp && !seen) print_verdict();
		tick(2);
	endtask

	task automatic t_reset();
		chk({en, curr, rng}, {4'hf, 4'h0, 16'h9999}, "reset outs");
		chk(drv, 64'h0, "reset words");
		rd_chk(2'h0, 8'h00);
		rd_chk(2'h1, 8'h15);
		rd_chk(2'h2, 8'h00);
		rd_chk(2'h3, 8'h00);
	endtask

	task automatic t_modes();
		logic [7:0] m[4] = '{8'h18, 8'h17, 8'h19, 8'h22};
		for (int i = 0; i < 4; i++) cpu.prm(1'b1, 4'(2 + i), m[i]);
		tick(2);
		chk({en, curr, rng}, {4'hf, 4'h8, 16'h2978}, "mode decode");
	endtask

	task automatic t_words();
		logic [1:0]  c[8] = '{0, 0, 0, 1, 1, 2, 2, 3};
		logic [15:0] w[8] = '{16'h7fff, 16'h6c00, 16'h8000, 16'he000, 16'h6c01,
			16'h8000, 16'h9400, 16'h7eff};
		logic [15:0] e[8] = '{16'h7eff, 16'h6c00, 16'h0000, 16'he500, 16'h6c01,
			16'h8100, 16'h9400, 16'h7eff};
		logic [1:0]  f[8] = '{2'b10, 2'b00, 2'b01, 2'b01, 2'b10, 2'b01, 2'b00, 2'b10};
		for (int i = 0; i < 8; i++) begin
			cpu.word(c[i], w[i]);
			tick(2);
			chk(drv[c[i]*16 +: 16], e[i], "drive word");
			chk({over[c[i]], under[c[i]]}, f[i], "region");
		end
	endtask

	task automatic t_param();
		cpu.prm(1'b0, 4'h0, 8'h0f);
		cpu.prm(1'b1, 4'h0, 8'h40);
		cpu.prm(1'b1, 4'h2, 8'h23);
		cpu.prm(1'b1, 4'h3, 8'h24);
		cpu.prm(1'b1, 4'h4, 8'h00);
		tick(2);
		chk({en, curr, rng[7:0]}, {4'hb, 4'hb, 8'h43}, "mode decode 2");
		chk(drv[47:32], 16'h0000, "off drive");
		cpu.prm(1'b1, 4'h5, 8'h55);
		wait_irq(1'b1, 8'h81, 8'h81);
		chk(en[3], 1'b0, "invalid off");
		cpu.prm(1'b1, 4'h5, 8'h18);
		wait_irq(1'b1, 8'h00, 8'hff);
	endtask

	task automatic t_sources();
		for (int s = 0; s < 3; s++) begin
			wire_break[0] = (s == 0);
			short_gnd[0] = (s == 1);
			manual_sw[0] = (s == 2);
			wait_irq(1'b1, 8'h09, 8'hff);
			{wire_break, short_gnd, manual_sw} = 12'h000;
			wait_irq(1'b1, 8'h00, 8'hff);
		end
		wire_break[3] = 1'b1;
		wait_irq(1'b0, 8'h00, 8'hff);
		wire_break[3] = 1'b0;
		ext_ok = 1'b0;
		wait_irq(1'b1, 8'h15, 8'hff);
		ext_ok = 1'b1;
		wait_irq(1'b1, 8'h00, 8'hff);
	endtask

	task automatic t_gate();
		cpu.prm(1'b0, 4'h0, 8'h0e);
		short_gnd[0] = 1'b1;
		wait_irq(1'b0, 8'h00, 8'hff);
		rd_chk(2'h0, 8'h00);
		cpu.prm(1'b1, 4'h0, 8'h00);
		cpu.prm(1'b0, 4'h0, 8'h0f);
		wait_irq(1'b0, 8'h00, 8'hff);
		rd_chk(2'h0, 8'h09);
		short_gnd[0] = 1'b0;
		run_in = 1'b1;
		tick(3);
		rd_chk(2'h0, 8'h00);
		rd_chk(2'h2, 8'h04);
	endtask

	initial begin
		miscompares = 0;
		num_checks = 0;
		nrst_in = 1'b0;
		run_in = 1'b0;
		ext_ok = 1'b1;
		{wire_break, short_gnd, manual_sw} = 12'h000;
		repeat (12) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		tick(2);
		t_reset();
		t_modes();
		t_words();
		t_param();
		t_sources();
		t_gate();
		print_verdict();
	end
endmodule
